//--- src/esbr_defs.svh
// shared constants of the sense, border and resolution command block
`ifndef ESBR_DEFS_SVH
`define ESBR_DEFS_SVH
// command bytes
`define ESBR_CMD_TEMP_MEASURE 8'h40
`define ESBR_CMD_TEMP_OFFSET 8'h41
`define ESBR_CMD_BORDER_BLANK 8'h50
`define ESBR_CMD_SUPPLY_LOW 8'h51
`define ESBR_CMD_WINDOW_RES 8'h61
// reset values
`define ESBR_OFFSET_RESET 8'h00
`define ESBR_CFG_RESET 8'h97
`define ESBR_HORIZONTAL_PIXELS_RESET 10'h3c0
`define ESBR_VERTICAL_LINES_RESET 10'h2a8
`define ESBR_SUPPLY_RESET 8'h01
`define ESBR_BLANK_RESET 8'h14
// field layout
`define ESBR_OFFSET_MASK 8'h0e
`define ESBR_OFS_HI 3
`define ESBR_OFS_LO 1
`define ESBR_BORDER_HI 7
`define ESBR_BORDER_LO 5
`define ESBR_POL_BIT 4
`define ESBR_BLANK_HI 3
`define ESBR_BORDER_HIZ_CODE 3'h4
`define ESBR_BLANK_RSVD 4'hf
// temperature limits, sign-extended to nine bits
`define ESBR_TEMP_MIN 9'h1e7
`define ESBR_TEMP_MAX 9'h032
// blanking ms per code, code 0h in the low byte
`define ESBR_BLANK_TABLE {8'ha0, 8'h8c, 8'h78, 8'h64, 8'h50, 8'h3c, 8'h28, 8'h14, \
	8'h12, 8'h10, 8'h0e, 8'h0c, 8'h08, 8'h04, 8'h02}
// sequence positions
`define ESBR_PIDX_LAST 2'h3
`define ESBR_BIT_LAST 3'h7
// timing
`define ESBR_CLK_MHZ 50
`define ESBR_TEMP_MEAS_US 20
`define ESBR_SUPPLY_DET_US 10
`define ESBR_TEMP_MEAS_CYC (`ESBR_TEMP_MEAS_US * `ESBR_CLK_MHZ)
`define ESBR_SUPPLY_DET_CYC (`ESBR_SUPPLY_DET_US * `ESBR_CLK_MHZ)
`endif

//--- src/esbr_pkg.sv
// types of the sense, border and resolution command block
package esbr_pkg;
	// decoder activity; anything but idle holds busy low
	typedef enum logic [1:0] {
		ESBR_IDLE = 2'b00,
		ESBR_MEASURE = 2'b01,
		ESBR_DETECT = 2'b10
	} esbr_state_type;
endpackage : esbr_pkg

//--- src/esbr_link.sv
// serial link front end running on the host's serial clock
`timescale 1ns/1ps
`include "esbr_defs.svh"

module esbr_link
	import esbr_pkg::*;
(
	input wire logic scl, // serial clock from the host
	input wire logic resetn, // hardware reset, active low
	input wire logic cs_n, // chip select, active low
	input wire logic dc_sel, // low command, high parameter
	input wire logic rw_sel, // high means the host reads
	input wire logic sda_i, // serial data in
	input wire logic [7:0] rd_data, // result byte, static while idle
	output logic sda_o, // serial data out
	output logic sda_oe, // high while the device drives data
	output logic rx_toggle, // flips once per written byte
	output logic [7:0] rx_byte, // last written byte
	output logic rx_dc // select level of that byte
);
	// ----------------------------------------
	// frame bookkeeping
	// ----------------------------------------
	logic frame_rst_n; // counters clear while deselected
	logic reading; // result phase of a read-back command
	logic [2:0] bit_cnt_q; // bits taken on rising edges
	logic [2:0] tx_cnt_q; // bits sent, advanced on falling edges
	logic [6:0] shift_q; // first seven bits of a byte

	// the clock stops between frames, so select must clear the counters
	assign frame_rst_n = resetn & ~cs_n;
	assign reading = rw_sel & dc_sel; // R15

	// bit counter for incoming bytes
	always_ff @(posedge scl or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_q <= 3'h0;
		end else begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
	end

	// msb-first shifter
	always_ff @(posedge scl or negedge resetn) begin
		if (!resetn) begin
			shift_q <= 7'h00;
		end else begin
			shift_q <= {shift_q[5:0], sda_i};
		end
	end

	// ----------------------------------------
	// hand-off of written bytes
	// ----------------------------------------
	// byte and select stay put for a whole byte time, far longer than the
	// three system clocks the toggle needs to cross
	always_ff @(posedge scl or negedge resetn) begin
		if (!resetn) begin
			rx_byte <= 8'h00;
			rx_dc <= 1'b0;
			rx_toggle <= 1'b0;
		end else if (bit_cnt_q == `ESBR_BIT_LAST && !reading) begin
			rx_byte <= {shift_q, sda_i};
			rx_dc <= dc_sel; // R15
			rx_toggle <= ~rx_toggle;
		end
	end

	// ----------------------------------------
	// read-back output
	// ----------------------------------------
	// bit 7 is ready before the first rising edge, later bits follow falls
	always_ff @(negedge scl or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			tx_cnt_q <= 3'h0;
		end else begin
			tx_cnt_q <= tx_cnt_q + 3'h1;
		end
	end

	// result only moves while busy is low, when the host may not read
	assign sda_o = rd_data[`ESBR_BIT_LAST - tx_cnt_q]; // R15
	assign sda_oe = ~cs_n & reading; // R15
endmodule : esbr_link

//--- src/esbr_core.sv
// command decode and settings for temperature, border, supply and resolution
`timescale 1ns/1ps
// Notes on behaviour
// R1: measure command holds busy, then result reads
// R2: reading is signed degrees, -25 to 50
// R3: offset is signed three bits at 3:1
// R4: border and interval byte resets to 97h
// R5: bits 7:5 pick border drive, polarity aware
// R6: bit 4 low inverts the pixel polarity
// R7: bits 3:0 pick blanking time, Fh reserved
// R8: host tunes blanking for a stable common voltage
// R9: supply detect holds busy, bit 0 low means low
// R10: four bytes set horizontal then vertical resolution
// R11: host keeps horizontal a multiple of four
// R12: host keeps vertical at least 420 lines
// R13: last panel or window command sets resolution
// R14: host waits for busy high before continuing
// R15: select pins split commands, parameters and reads
`include "esbr_defs.svh"

module esbr_core
	import esbr_pkg::*;
(
	input wire logic CLK, // system clock
	input wire logic RESETN, // hardware reset, active low
	input wire logic SCL, // serial clock from the host
	input wire logic CS_N, // chip select, active low
	input wire logic DC_SEL, // low command, high parameter
	input wire logic RW_SEL, // high while the host reads
	input wire logic SDA_I, // serial data in
	output logic SDA_O, // serial data out
	output logic SDA_OE, // high while the device drives data
	output logic BUSY_N, // low while measuring or detecting
	input wire logic [7:0] TEMP_RAW, // sensor code, signed degrees
	input wire logic SUPPLY_OK, // comparator, low when supply is low
	output logic SENSOR_EN, // temperature sensor switched on
	input wire logic PANEL_RES_LOAD, // panel setting resolution pulse
	input wire logic [9:0] PANEL_H, // resolution from panel setting
	input wire logic [9:0] PANEL_V, // resolution from panel setting
	output logic [7:0] TEMP_OFFSET, // offset byte, bits 3:1 used
	output logic [1:0] BORDER_GRAY, // border gray level
	output logic BORDER_HIZ, // border left floating
	output logic PIXEL_INVERT, // pixel codes inverted
	output logic [7:0] BLANK_MS, // blanking interval in ms
	output logic [9:0] H_PIXELS, // horizontal resolution in effect
	output logic [9:0] V_LINES // vertical resolution in effect
);
	// ----------------------------------------
	// constants
	// ----------------------------------------
	localparam logic [119:0] BLANK_TABLE = `ESBR_BLANK_TABLE; // ms per code
	localparam logic [10:0] MEAS_LOAD = 11'(`ESBR_TEMP_MEAS_CYC - 1); // cycles less one
	localparam logic [10:0] DET_LOAD = 11'(`ESBR_SUPPLY_DET_CYC - 1); // cycles less one
	// busy span plus the start cycle, so the rise of busy lies inside the range
	localparam int MEAS_WAIT = `ESBR_TEMP_MEAS_CYC + 1; // cycles to busy rising
	localparam int DET_WAIT = `ESBR_SUPPLY_DET_CYC + 1; // cycles to busy rising

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic rx_toggle; // flips per byte, serial clock domain
	logic [7:0] rx_byte; // byte held by the link
	logic rx_dc; // its select level
	logic tog_s1_q; // first sync stage
	logic tog_s2_q; // second sync stage
	logic tog_s3_q; // edge detect history
	logic rx_stb; // one pulse per written byte
	logic wr_stb; // byte accepted while idle
	logic cmd_stb; // command byte accepted
	logic par_stb; // parameter byte accepted
	logic [7:0] temp_s1_q; // sensor sync, first stage
	logic [7:0] temp_s2_q; // sensor sync, second stage
	logic supply_s1_q; // comparator sync, first stage
	logic supply_s2_q; // comparator sync, second stage
	logic pnl_wr_q; // panel load pulse delayed one cycle
	esbr_state_type state_q; // decoder activity
	logic [10:0] timer_q; // cycles left in the activity
	logic [7:0] cmd_q; // last command byte
	logic [1:0] pidx_q; // parameter index for that command
	logic [7:0] offset_q; // temperature offset byte
	logic [7:0] cfg_q; // border, polarity and blanking byte
	logic [7:0] blank_ms_q; // blanking interval in effect
	logic [9:0] hstage_q; // horizontal value being collected
	logic [1:0] vstage_q; // vertical high bits being collected
	logic [9:0] horizontal_pixels_q; // horizontal resolution in effect
	logic [9:0] vertical_lines_q; // vertical resolution in effect
	logic [8:0] temp_sum; // reading plus offset, nine bits
	logic [7:0] temp_res; // saturated reading
	logic [7:0] rd_data_q; // last result byte
	logic [1:0] border_gray_d; // border level from the setting
	logic border_hiz_d; // floating border from the setting
	logic [1:0] border_gray_q; // registered border level
	logic border_hiz_q; // registered floating flag
	logic pix_inv_q; // registered polarity
	logic meas_start; // measure command taken
	logic det_start; // detect command taken
	logic res_commit; // fourth resolution byte taken

	// ----------------------------------------
	// serial link
	// ----------------------------------------
	esbr_link u_link (
		.scl(SCL),
		.resetn(RESETN),
		.cs_n(CS_N),
		.dc_sel(DC_SEL),
		.rw_sel(RW_SEL),
		.sda_i(SDA_I),
		.rd_data(rd_data_q),
		.sda_o(SDA_O),
		.sda_oe(SDA_OE),
		.rx_toggle(rx_toggle),
		.rx_byte(rx_byte),
		.rx_dc(rx_dc)
	);

	// toggle crossing; only the second stage feeds the edge detect
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
			tog_s3_q <= 1'b0;
		end else begin
			tog_s1_q <= rx_toggle;
			tog_s2_q <= tog_s1_q;
			tog_s3_q <= tog_s2_q;
		end
	end

	assign rx_stb = tog_s2_q ^ tog_s3_q;
	// bytes during an activity are dropped; the host must wait for busy
	assign wr_stb = rx_stb && (state_q == ESBR_IDLE); // R14
	assign cmd_stb = wr_stb && !rx_dc; // R15
	assign par_stb = wr_stb && rx_dc; // R15
	assign meas_start = cmd_stb && (rx_byte == `ESBR_CMD_TEMP_MEASURE);
	assign det_start = cmd_stb && (rx_byte == `ESBR_CMD_SUPPLY_LOW);
	assign res_commit = par_stb && (cmd_q == `ESBR_CMD_WINDOW_RES)
		&& (pidx_q == `ESBR_PIDX_LAST);

	// ----------------------------------------
	// analog input synchronisers
	// ----------------------------------------
	// the sensor code settles long before the measurement ends, so a
	// per-bit sync cannot tear the sampled value
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			temp_s1_q <= 8'h00;
			temp_s2_q <= 8'h00;
			supply_s1_q <= 1'b1;
			supply_s2_q <= 1'b1;
		end else begin
			temp_s1_q <= TEMP_RAW;
			temp_s2_q <= temp_s1_q;
			supply_s1_q <= SUPPLY_OK;
			supply_s2_q <= supply_s1_q;
		end
	end

	// ----------------------------------------
	// activity sequencer
	// ----------------------------------------
	// measure and detect hold busy for a fixed count
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= ESBR_IDLE;
			timer_q <= 11'h000;
		end else begin
			case (state_q)
				ESBR_IDLE: begin
					if (meas_start) begin
						state_q <= ESBR_MEASURE; // R1
						timer_q <= MEAS_LOAD; // R1
					end else if (det_start) begin
						state_q <= ESBR_DETECT; // R9
						timer_q <= DET_LOAD; // R9
					end
				end
				ESBR_MEASURE, ESBR_DETECT: begin
					if (timer_q == 11'h000) begin
						state_q <= ESBR_IDLE;
					end else begin
						timer_q <= timer_q - 11'h001;
					end
				end
				default: begin
					state_q <= ESBR_IDLE;
				end
			endcase
		end
	end

	assign BUSY_N = (state_q == ESBR_IDLE); // R1
	assign SENSOR_EN = (state_q == ESBR_MEASURE); // R1

	// ----------------------------------------
	// results
	// ----------------------------------------
	// offset field sign-extended from bits 3:1
	assign temp_sum = {temp_s2_q[7], temp_s2_q}
		+ {{6{offset_q[`ESBR_OFS_HI]}}, offset_q[`ESBR_OFS_HI:`ESBR_OFS_LO]}; // R3

	// clamp to the reportable span rather than wrap
	always_comb begin
		if ($signed(temp_sum) < $signed(`ESBR_TEMP_MIN)) begin
			temp_res = 8'(`ESBR_TEMP_MIN); // R2
		end else if ($signed(temp_sum) > $signed(`ESBR_TEMP_MAX)) begin
			temp_res = 8'(`ESBR_TEMP_MAX); // R2
		end else begin
			temp_res = temp_sum[7:0];
		end
	end

	// result byte changes only as an activity ends
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rd_data_q <= `ESBR_SUPPLY_RESET;
		end else if (state_q == ESBR_MEASURE && timer_q == 11'h000) begin
			rd_data_q <= temp_res; // R1
		end else if (state_q == ESBR_DETECT && timer_q == 11'h000) begin
			rd_data_q <= {7'h00, supply_s2_q}; // R9
		end
	end

	// ----------------------------------------
	// command and parameter tracking
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cmd_q <= 8'h00;
			pidx_q <= 2'h0;
		end else if (cmd_stb) begin
			cmd_q <= rx_byte; // R15
			pidx_q <= 2'h0;
		end else if (par_stb) begin
			pidx_q <= pidx_q + 2'h1;
		end
	end

	// temperature offset, unused bits forced to zero
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			offset_q <= `ESBR_OFFSET_RESET; // R3
		end else if (par_stb && cmd_q == `ESBR_CMD_TEMP_OFFSET && pidx_q == 2'h0) begin
			offset_q <= rx_byte & `ESBR_OFFSET_MASK; // R3
		end
	end

	// border, polarity and blanking byte
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cfg_q <= `ESBR_CFG_RESET; // R4
		end else if (par_stb && cmd_q == `ESBR_CMD_BORDER_BLANK && pidx_q == 2'h0) begin
			cfg_q <= rx_byte; // R4
		end
	end

	// blanking time; the reserved code leaves the old time in force
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			blank_ms_q <= `ESBR_BLANK_RESET; // R7
		end else if (par_stb && cmd_q == `ESBR_CMD_BORDER_BLANK && pidx_q == 2'h0
			&& rx_byte[`ESBR_BLANK_HI:0] != `ESBR_BLANK_RSVD) begin
			blank_ms_q <= BLANK_TABLE[{rx_byte[`ESBR_BLANK_HI:0], 3'h0} +: 8]; // R7
		end
	end

	// ----------------------------------------
	// border and polarity decode
	// ----------------------------------------
	// codes above 100 are undefined; floating is the safe choice
	always_comb begin
		border_gray_d = 2'h0;
		border_hiz_d = 1'b1;
		if (cfg_q[`ESBR_POL_BIT]) begin
			if (cfg_q[`ESBR_BORDER_HI] == 1'b0) begin
				border_gray_d = cfg_q[`ESBR_BORDER_LO+1:`ESBR_BORDER_LO]; // R5
				border_hiz_d = 1'b0;
			end
		end else begin
			if (cfg_q[`ESBR_BORDER_HI:`ESBR_BORDER_LO] == `ESBR_BORDER_HIZ_CODE) begin
				border_hiz_d = 1'b0; // R5
			end else if (cfg_q[`ESBR_BORDER_HI] == 1'b0
				&& cfg_q[`ESBR_BORDER_LO+1:`ESBR_BORDER_LO] != 2'h0) begin
				border_gray_d = 2'h0 - cfg_q[`ESBR_BORDER_LO+1:`ESBR_BORDER_LO]; // R5
				border_hiz_d = 1'b0;
			end
		end
	end

	// registered so the driving stage sees clean levels
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			border_gray_q <= 2'h0;
			border_hiz_q <= 1'b1;
			pix_inv_q <= 1'b0;
		end else begin
			border_gray_q <= border_gray_d; // R5
			border_hiz_q <= border_hiz_d; // R5
			pix_inv_q <= ~cfg_q[`ESBR_POL_BIT]; // R6
		end
	end

	// ----------------------------------------
	// resolution
	// ----------------------------------------
	// high bits then low bits, horizontal before vertical
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			hstage_q <= `ESBR_HORIZONTAL_PIXELS_RESET;
			vstage_q <= 2'h0;
		end else if (par_stb && cmd_q == `ESBR_CMD_WINDOW_RES) begin
			case (pidx_q)
				2'h0: hstage_q[9:8] <= rx_byte[1:0]; // R10
				2'h1: hstage_q[7:0] <= rx_byte; // R10
				2'h2: vstage_q <= rx_byte[1:0]; // R10
				default: begin
				end
			endcase
		end
	end

	// panel pulse is also registered one cycle; only the c_panel_res cover uses the delayed copy
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pnl_wr_q <= 1'b0;
		end else begin
			pnl_wr_q <= PANEL_RES_LOAD;
		end
	end

	// whichever source wrote last stands; the window command wins a tie
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			horizontal_pixels_q <= `ESBR_HORIZONTAL_PIXELS_RESET; // R10
			vertical_lines_q <= `ESBR_VERTICAL_LINES_RESET; // R10
		end else if (res_commit) begin
			horizontal_pixels_q <= hstage_q; // R13
			vertical_lines_q <= {vstage_q, rx_byte}; // R13
		end else if (PANEL_RES_LOAD) begin
			horizontal_pixels_q <= PANEL_H; // R13
			vertical_lines_q <= PANEL_V; // R13
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign TEMP_OFFSET = offset_q;
	assign BORDER_GRAY = border_gray_q;
	assign BORDER_HIZ = border_hiz_q;
	assign PIXEL_INVERT = pix_inv_q;
	assign BLANK_MS = blank_ms_q;
	assign H_PIXELS = horizontal_pixels_q;
	assign V_LINES = vertical_lines_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	a_meas_busy: assert property ( // R1
		meas_start |=> (!BUSY_N && SENSOR_EN) [*8] ##[1:MEAS_WAIT] BUSY_N)
		else $error("measurement busy window wrong");
	a_temp_range: assert property ( // R2
		(state_q == ESBR_MEASURE && timer_q == 11'h000)
		|=> ($signed(rd_data_q) >= -25 && $signed(rd_data_q) <= 50))
		else $error("temperature result out of range");
	a_offset_bits: assert property ( // R3
		(offset_q[7:4] == 4'h0) && (offset_q[0] == 1'b0))
		else $error("offset byte has unused bits set");
	a_cfg_reset: assert property ( // R4
		$rose(RESETN) |-> (cfg_q == 8'h97 && BLANK_MS == 8'h14))
		else $error("border byte not at reset value");
	a_border_map: assert property ( // R5
		(cfg_q[7:4] == 4'h9) |=> (BORDER_HIZ && $stable(cfg_q)) or !$stable(cfg_q))
		else $error("default border code not floating");
	a_border_inv: assert property ( // R5
		(cfg_q[7:4] == 4'h2) |=> (!BORDER_HIZ && BORDER_GRAY == 2'h3) or !$stable(cfg_q))
		else $error("inverted border code mapped wrong");
	a_polarity: assert property ( // R6
		##1 PIXEL_INVERT == !$past(cfg_q[4]))
		else $error("pixel polarity does not follow setting");
	a_blank_rsvd: assert property ( // R7
		(par_stb && cmd_q == 8'h50 && rx_byte[3:0] == 4'hf) |=> $stable(BLANK_MS))
		else $error("reserved blanking code changed the time");
	a_supply_read: assert property ( // R9
		det_start |=> !BUSY_N [*8] ##[1:DET_WAIT] (BUSY_N && rd_data_q[0] == $past(supply_s2_q)))
		else $error("supply result or busy wrong");
	a_res_commit: assert property ( // R10
		res_commit |=> (H_PIXELS == $past(hstage_q) && V_LINES[7:0] == $past(rx_byte)))
		else $error("resolution bytes not applied");
	a_res_last: assert property ( // R13
		(PANEL_RES_LOAD && !res_commit) |=> (H_PIXELS == $past(PANEL_H) && V_LINES == $past(PANEL_V)))
		else $error("panel resolution not applied");

	c_measure: cover property (meas_start ##[1:MEAS_WAIT] $rose(BUSY_N));
	c_detect: cover property (det_start ##[1:DET_WAIT] $rose(BUSY_N));
	c_window_res: cover property (res_commit);
	c_panel_res: cover property (PANEL_RES_LOAD ##1 pnl_wr_q);
endmodule : esbr_core

//--- tb/esbr_host_model.sv
// host side model that drives the serial command link
`timescale 1ns/1ps

module esbr_host_model (
	output logic scl, // serial clock, still outside bytes
	output logic cs_n, // chip select, active low
	output logic dc_sel, // low command, high parameter
	output logic rw_sel, // high while the host reads
	output logic sda_h, // data the host puts on the line
	input wire logic sda_w // resolved level of the data line
);
	// ----------------------------
	// idle levels and byte tasks
	// ----------------------------
	initial begin
		scl = 1'b0;
		cs_n = 1'b1;
		dc_sel = 1'b0;
		rw_sel = 1'b0;
		sda_h = 1'b0;
	end

	// one written byte, msb first, data moved while scl is low
	task automatic send(input logic dc, input logic [7:0] b);
		#7 cs_n = 1'b0;
		dc_sel = dc;
		rw_sel = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			sda_h = b[i];
			#80 scl = 1'b1;
			#80 scl = 1'b0;
		end
		#80 cs_n = 1'b1;
		// a released line must not look like it kept its last bit
		sda_h = ~sda_h;
	endtask : send

	// one read byte, each bit taken at a rising scl edge
	task automatic read(output logic [7:0] b);
		#7 cs_n = 1'b0;
		dc_sel = 1'b1;
		rw_sel = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			#80 scl = 1'b1;
			b[i] = sda_w;
			#80 scl = 1'b0;
		end
		#80 cs_n = 1'b1;
		rw_sel = 1'b0;
	endtask : read
endmodule : esbr_host_model

//--- tb/epd_sense_border_resolution_cmds_test.sv
// self-checking bench of the sense, border and resolution command block
`timescale 1ns/1ps
`include "esbr_defs.svh"
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
	$display("mismatch %s expected %h seen %h", nm, e, a); end end

module epd_sense_border_resolution_cmds_test
	import esbr_pkg::*;
;
	typedef struct {int what; logic [9:0] exp;} esbr_note_type;
	logic clk = 1'b0;
	logic resetn;
	logic scl, cs_n, dc_sel, rw_sel, sda_h, sda_w, sda_o, sda_oe, busy_n, sensor_en;
	logic [7:0] temp_raw, temp_offset, blank_ms, rd, cur_ofs, ms;
	logic supply_ok, panel_res_load, border_hiz, pixel_invert;
	logic [9:0] panel_h, panel_v, h_pixels, v_lines, h, v;
	logic [1:0] border_gray;
	logic [2:0] bd;
	logic [31:0] seed = 32'h00016267;
	int n_fail = 0;
	int total_checks = 0;
	int t;
	int e;
	esbr_note_type notes[$];
	esbr_note_type nt;
	event look;
	logic [7:0] tbl[15] = '{8'h02, 8'h04, 8'h08, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'h14,
		8'h28, 8'h3c, 8'h50, 8'h64, 8'h78, 8'h8c, 8'ha0};
	logic [9:0] rv[7] = '{10'h000, 10'h014, 10'h001, 10'h000, 10'h3c0, 10'h2a8, 10'h001};

	// --------------------------
	// clock, wiring, instances
	// --------------------------
	always #10 clk = ~clk;
	// data line: device wins while it drives, else the host level
	assign sda_w = sda_oe ? sda_o : sda_h;

	esbr_host_model host (.scl(scl), .cs_n(cs_n), .dc_sel(dc_sel), .rw_sel(rw_sel),
		.sda_h(sda_h), .sda_w(sda_w));

	esbr_core uut (.CLK(clk), .RESETN(resetn), .SCL(scl), .CS_N(cs_n), .DC_SEL(dc_sel),
		.RW_SEL(rw_sel), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe), .BUSY_N(busy_n),
		.TEMP_RAW(temp_raw), .SUPPLY_OK(supply_ok), .SENSOR_EN(sensor_en),
		.PANEL_RES_LOAD(panel_res_load), .PANEL_H(panel_h), .PANEL_V(panel_v),
		.TEMP_OFFSET(temp_offset), .BORDER_GRAY(border_gray), .BORDER_HIZ(border_hiz),
		.PIXEL_INVERT(pixel_invert), .BLANK_MS(blank_ms), .H_PIXELS(h_pixels),
		.V_LINES(v_lines));

	// --------------------------
	// helpers
	// --------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// expected border as {hiz, gray}, polarity aware
	function automatic logic [2:0] border(input logic [2:0] b, input logic pol);
		if (b == 3'h4) return pol ? 3'h4 : 3'h0;
		if (b == 3'h0 && !pol) return 3'h4;
		return pol ? {1'b0, b[1:0]} : {1'b0, 2'(3'h4 - b)};
	endfunction : border

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic note(input int w, input logic [9:0] x);
		nt.what = w;
		nt.exp = x;
		notes.push_back(nt);
	endtask : note

	task automatic wait_busy(input logic lvl, input int bound);
		int k;
		k = 0;
		while (busy_n !== lvl && k < bound) begin
			@(negedge clk);
			k++;
		end
		// a bound used up ends the run
		if (k >= bound) begin
			n_fail++;
			report_and_stop();
		end
	endtask : wait_busy

	task automatic wr(input logic [7:0] cmd, input logic [7:0] p);
		host.send(1'b0, cmd);
		host.send(1'b1, p);
		repeat (6) @(negedge clk);
	endtask : wr

	// measure or detect, with a write thrown in while busy that must be dropped
	task automatic sense(input logic [7:0] cmd, input logic [7:0] x, input int bound);
		host.send(1'b0, cmd);
		repeat (8) @(negedge clk);
		note(7, 10'h000);
		note(9, {9'h0, cmd == `ESBR_CMD_TEMP_MEASURE});
		->look;
		wr(`ESBR_CMD_TEMP_OFFSET, ~cur_ofs & 8'h0e);
		wait_busy(1'b1, bound);
		note(0, {2'b0, x});
		note(1, {2'b0, cur_ofs});
		host.read(rd);
		->look;
	endtask : sense

	// --------------------------
	// result watcher
	// --------------------------
	always @(look) begin
		while (notes.size() > 0) begin
			nt = notes.pop_front();
			case (nt.what)
				0: `CHK("result", nt.exp[7:0], rd)
				1: `CHK("offset", nt.exp[7:0], temp_offset)
				2: `CHK("blank", nt.exp[7:0], blank_ms)
				3: `CHK("hiz", nt.exp[0], border_hiz)
				4: `CHK("invert", nt.exp[0], pixel_invert)
				5: `CHK("hpix", nt.exp, h_pixels)
				6: `CHK("vlines", nt.exp, v_lines)
				7: `CHK("busy", nt.exp[0], busy_n)
				8: `CHK("gray", nt.exp[1:0], border_gray)
				default: `CHK("sensor", nt.exp[0], sensor_en)
			endcase
		end
	end

	// --------------------------
	// main sequence
	// --------------------------
	initial begin
		resetn = 1'b0;
		temp_raw = 8'h00;
		supply_ok = 1'b1;
		panel_res_load = 1'b0;
		panel_h = 10'h000;
		panel_v = 10'h000;
		cur_ofs = 8'h00;
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		repeat (2) @(negedge clk);
		for (int i = 0; i < 7; i++) note(i + 1, rv[i]);
		->look;
		// border codes 000 to 100 under both polarities, every blanking code
		ms = 8'h14;
		for (int i = 0; i < 16; i++) begin
			bd = border(3'(i % 5), i[1]);
			wr(`ESBR_CMD_BORDER_BLANK, {3'(i % 5), i[1], 4'(i)});
			if (i < 15) ms = tbl[i];
			note(2, {2'b0, ms});
			note(4, {9'h0, ~i[1]});
			note(3, {9'h0, bd[2]});
			if (!bd[2]) note(8, {8'h0, bd[1:0]});
			->look;
		end
		// every offset, with clamping at both ends
		for (int o = 0; o < 8; o++) begin
			cur_ofs = {4'h0, 3'(o), 1'b0};
			wr(`ESBR_CMD_TEMP_OFFSET, cur_ofs);
			t = int'(xs() % 32'h56) - 30;
			if (o == 0) t = 55;
			if (o == 4) t = -22;
			temp_raw = 8'(t);
			e = t + (o >= 4 ? o - 8 : o);
			e = e < -25 ? -25 : (e > 50 ? 50 : e);
			sense(`ESBR_CMD_TEMP_MEASURE, 8'(e), 1100);
		end
		for (int s = 0; s < 2; s++) begin
			// the read ends between clock edges; move the pin on a falling edge
			@(negedge clk);
			supply_ok = s[0];
			sense(`ESBR_CMD_SUPPLY_LOW, {7'h0, s[0]}, 600);
		end
		// window command and panel load, each overriding the other
		for (int r = 0; r < 3; r++) begin
			seed = xs();
			h = {seed[9:2], 2'b00};
			v = 10'h1a4 + 10'(seed[25:16] % 10'h25c);
			host.send(1'b0, `ESBR_CMD_WINDOW_RES);
			host.send(1'b1, {6'h0, h[9:8]});
			host.send(1'b1, h[7:0]);
			host.send(1'b1, {6'h0, v[9:8]});
			host.send(1'b1, v[7:0]);
			repeat (6) @(negedge clk);
			note(5, h);
			note(6, v);
			->look;
			panel_h = ~h;
			panel_v = v ^ 10'h155;
			panel_res_load = 1'b1;
			@(negedge clk);
			panel_res_load = 1'b0;
			@(negedge clk);
			note(5, ~h);
			note(6, v ^ 10'h155);
			->look;
		end
		@(negedge clk);
		report_and_stop();
	end
endmodule : epd_sense_border_resolution_cmds_test
